// [rtl/tracking_sequencer.sv]
/*
 Dual supply tracking sequencer: shutdown output, gate drive state,
 bleeder, latched fault timer, Avalon-MM register slave, interrupt.
 Assumes comparator inputs synchronous to clk_sys (50 MHz).
*/
// Our own choices: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
module tracking_sequencer
   import tracker_pkg::*;
#(
   parameter logic [TIMER_W-1:0] FAULT_CYCLES = FAULT_CYCLES_DEF
)(
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              ce,
   input  wire logic              vccAboveHold,
   input  wire logic              vccAboveOn,
   input  wire logic              lockoutAbove,
   input  wire logic              ioBelowCore,
   input  wire logic              outputShorted,
   input  wire logic              feedbackAbove,
   input  wire logic [ADDR_W-1:0] address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   output logic [31:0]            readdata,
   output logic                   waitrequest,
   output logic                   supplyShutdownOut,
   output logic                   shutdownHoldActive,
   output gate_t                  shuntGateDrive,
   output logic                   bleederEnable,
   output logic                   faultLatched,
   output logic                   irq
);
   logic                forceOffQ;
   logic [EV_W-1:0]     irqStatQ;
   logic [EV_W-1:0]     irqMaskQ;
   logic                ackQ;
   logic                sdoD;
   logic                timerRun;
   logic                faultClear;
   logic [TIMER_W-1:0]  timerCount;
   logic [EV_W-1:0]     events;
   logic                gateHighPrevQ;
   logic                faultPrevQ;
   logic                sdoPrevQ;
   logic                wrAccept;
   logic [31:0]         statusWord;
   logic [31:0]         readD;

   // Gate selection runs independently of the fault latch
   gate_drive_select u_gate (
      .clk_sys       (clk_sys),
      .rst_n         (rst_n),
      .ce            (ce),
      .vccAboveOn    (vccAboveOn),
      .ioBelowCore   (ioBelowCore),
      .outputShorted (outputShorted),
      .feedbackAbove (feedbackAbove),
      .gateState     (shuntGateDrive)
   );

   assign timerRun =
      supplyShutdownOut && (shuntGateDrive != GATE_LOW);
   // Supply or lockout dropping is the only unlatch path
   assign faultClear = !vccAboveOn || !lockoutAbove;

   fault_timer #(
      .LIMIT (FAULT_CYCLES)
   ) u_timer (
      .clk_sys (clk_sys),
      .rst_n   (rst_n),
      .ce      (ce),
      .run     (timerRun),
      .clear   (faultClear),
      .count   (timerCount),
      .faultQ  (faultLatched)
   );

   // Shutdown output condition
   always_comb begin
      sdoD = 1'b1;
      if (!lockoutAbove)
         sdoD = 1'b0;
      if (!vccAboveOn)
         sdoD = 1'b0;
      if (faultLatched)
         sdoD = 1'b0;
      if (forceOffQ)
         sdoD = 1'b0;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         supplyShutdownOut <= 1'b0;
      else if (ce)
         supplyShutdownOut <= sdoD;
   end

   // Output is actively pulled low while off, once supply passes holding level
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         shutdownHoldActive <= 1'b0;
      else if (ce)
         shutdownHoldActive <= vccAboveHold && !sdoD;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         bleederEnable <= 1'b0;
      else if (ce)
         bleederEnable <= !sdoD && vccAboveOn;
   end

   // Avalon-MM slave: one wait cycle per access
   assign waitrequest = (read || write) && !ackQ;
   assign wrAccept    = write && ackQ && ce;

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         ackQ <= 1'b0;
      else if (ce)
         ackQ <= (read || write) && !ackQ;
   end

   always_comb begin
      statusWord = '0;
      statusWord[ST_SDO]             = supplyShutdownOut;
      statusWord[ST_GATE +: 3]       = shuntGateDrive;
      statusWord[ST_BLEED]           = bleederEnable;
      statusWord[ST_FAULT]           = faultLatched;
      statusWord[ST_VCC_ON]          = vccAboveOn;
      statusWord[ST_LOCK]            = lockoutAbove;
      statusWord[ST_HOLD]            = shutdownHoldActive;
   end

   always_comb begin
      readD = '0;
      case (address)
         OFS_CTRL:
            readD[CTRL_FORCE_OFF] = forceOffQ;
         OFS_STATUS:
            readD = statusWord;
         OFS_IRQ_STAT:
            readD[EV_W-1:0] = irqStatQ;
         OFS_IRQ_MASK:
            readD[EV_W-1:0] = irqMaskQ;
         OFS_TIMER:
            readD[TIMER_W-1:0] = timerCount;
         default:
            readD = '0;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         readdata <= '0;
      else if (ce && read && !ackQ)
         readdata <= readD;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         forceOffQ <= CTRL_RST;
      else if (wrAccept && address == OFS_CTRL)
         forceOffQ <= writedata[CTRL_FORCE_OFF];
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         irqMaskQ <= MASK_RST;
      else if (wrAccept && address == OFS_IRQ_MASK)
         irqMaskQ <= writedata[EV_W-1:0];
   end

   // Event edge detection
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         gateHighPrevQ <= 1'b0;
         faultPrevQ    <= 1'b0;
         sdoPrevQ      <= 1'b0;
      end else if (ce) begin
         gateHighPrevQ <= shuntGateDrive == GATE_HIGH;
         faultPrevQ    <= faultLatched;
         sdoPrevQ      <= supplyShutdownOut;
      end
   end

   always_comb begin
      events = '0;
      events[EV_FAULT]   = faultLatched && !faultPrevQ;
      events[EV_SDO_UP]  = supplyShutdownOut && !sdoPrevQ;
      events[EV_SDO_DN]  = !supplyShutdownOut && sdoPrevQ;
      events[EV_GATE_HI] =
         (shuntGateDrive == GATE_HIGH) && !gateHighPrevQ;
   end

   // Sticky status, write one to clear; a new event wins
   genvar gi;
   generate
      for (gi = 0; gi < EV_W; gi++) begin : g_stat
         always_ff @(posedge clk_sys) begin
            if (!rst_n)
               irqStatQ[gi] <= 1'b0;
            else if (ce) begin
               if (events[gi])
                  irqStatQ[gi] <= 1'b1;
               else if (wrAccept && address == OFS_IRQ_STAT &&
                        writedata[gi])
                  irqStatQ[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   assign irq = |(irqStatQ & irqMaskQ);

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_lockout_off;
      ce && !lockoutAbove |=> !supplyShutdownOut;
   endproperty
   a_lockout_off: assert property (p_lockout_off)
      else $error("shutdown high with lockout low");

   property p_vcc_off;
      ce && !vccAboveOn |=> !supplyShutdownOut;
   endproperty
   a_vcc_off: assert property (p_vcc_off)
      else $error("shutdown high with supply low");

   property p_fault_off;
      ce && faultLatched |=> !supplyShutdownOut;
   endproperty
   a_fault_off: assert property (p_fault_off)
      else $error("shutdown high during fault");

   property p_hold_low;
      ce && vccAboveHold && !vccAboveOn |=> shutdownHoldActive;
   endproperty
   a_hold_low: assert property (p_hold_low)
      else $error("shutdown not actively held low");

   property p_on_cond;
      $rose(supplyShutdownOut) |->
         $past(lockoutAbove && vccAboveOn && !faultLatched);
   endproperty
   a_on_cond: assert property (p_on_cond)
      else $error("shutdown rose without conditions");

   property p_on_rise;
      ce && lockoutAbove && vccAboveOn && !faultLatched && !forceOffQ
         |=> supplyShutdownOut;
   endproperty
   a_on_rise: assert property (p_on_rise)
      else $error("shutdown stayed low when all good");

   property p_bleed;
      ce && vccAboveOn && !sdoD |=> bleederEnable && !supplyShutdownOut;
   endproperty
   a_bleed: assert property (p_bleed)
      else $error("bleeder off while shutdown low");

   property p_timer_idle;
      ce && !supplyShutdownOut |=> timerCount == '0;
   endproperty
   a_timer_idle: assert property (p_timer_idle)
      else $error("timer counting while shutdown low");

   property p_fault_clear;
      ce && faultLatched && !lockoutAbove |=> !faultLatched;
   endproperty
   a_fault_clear: assert property (p_fault_clear)
      else $error("fault not cleared by lockout cycle");

   property p_wait_one;
      (read || write) && !ackQ && ce |=> !waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one)
      else $error("waitrequest held too long");

   c_sdo_up: cover property ($rose(supplyShutdownOut));
   c_fault: cover property ($rose(faultLatched));
   c_reg: cover property (shuntGateDrive == GATE_REG);
   c_irq: cover property ($rose(irq));
endmodule // tracking_sequencer

// [rtl/tracker_pkg.sv]
/*
 Constants shared by the dual supply tracking sequencer: timing,
 register offsets, field positions, reset values and gate states.
 Assumes a 50 MHz system clock.
*/
package tracker_pkg;
   localparam int CLK_MHZ       = 50;
   localparam int FAULT_TIME_US = 15000;
   localparam int TIMER_W       = 20;
   localparam logic [TIMER_W-1:0] FAULT_CYCLES_DEF =
      TIMER_W'(FAULT_TIME_US * CLK_MHZ);

   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFS_CTRL     = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_TIMER    = 5'h10;

   localparam int CTRL_FORCE_OFF = 0;
   localparam logic CTRL_RST     = 1'h0;

   localparam int ST_SDO    = 0;
   localparam int ST_GATE   = 1;
   localparam int ST_BLEED  = 4;
   localparam int ST_FAULT  = 5;
   localparam int ST_VCC_ON = 6;
   localparam int ST_LOCK   = 7;
   localparam int ST_HOLD   = 8;

   localparam int EV_W       = 4;
   localparam int EV_FAULT   = 0;
   localparam int EV_SDO_UP  = 1;
   localparam int EV_SDO_DN  = 2;
   localparam int EV_GATE_HI = 3;
   localparam logic [EV_W-1:0] MASK_RST = 4'h0;

   typedef enum logic [2:0] {
      GATE_LOW  = 3'h1,
      GATE_REG  = 3'h2,
      GATE_HIGH = 3'h4
   } gate_t;
endpackage

// [rtl/gate_drive_select.sv]
/*
 Shunt gate drive state selection from comparator results.
 Assumes comparator inputs synchronous to clk_sys.
*/
`timescale 1ns/1ps
module gate_drive_select
   import tracker_pkg::*;
(
   input  wire logic clk_sys,
   input  wire logic rst_n,
   input  wire logic ce,
   input  wire logic vccAboveOn,
   input  wire logic ioBelowCore,
   input  wire logic outputShorted,
   input  wire logic feedbackAbove,
   output gate_t     gateState
);
   gate_t gateD;

   always_comb begin
      if (!vccAboveOn)
         gateD = GATE_LOW;
      else if (outputShorted)
         gateD = GATE_HIGH;
      else if (ioBelowCore)
         gateD = GATE_HIGH;
      else if (!feedbackAbove)
         gateD = GATE_REG;
      else
         gateD = GATE_LOW;
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         gateState <= GATE_LOW;
      else if (ce)
         gateState <= gateD;
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_gate_high;
      ce && vccAboveOn && ioBelowCore |=> gateState == GATE_HIGH;
   endproperty
   a_gate_high: assert property (p_gate_high)
      else $error("gate not high with io below core");
   property p_gate_reg;
      ce && vccAboveOn && !outputShorted && !ioBelowCore && !feedbackAbove
         |=> gateState == GATE_REG;
   endproperty
   a_gate_reg: assert property (p_gate_reg)
      else $error("gate not regulating");
   property p_gate_low;
      ce && vccAboveOn && !outputShorted && !ioBelowCore && feedbackAbove
         |=> gateState == GATE_LOW;
   endproperty
   a_gate_low: assert property (p_gate_low)
      else $error("gate not low in standby");
   property p_gate_off;
      ce && !vccAboveOn |=> gateState == GATE_LOW;
   endproperty
   a_gate_off: assert property (p_gate_off)
      else $error("gate active below turn-on");
   property p_short;
      ce && vccAboveOn && outputShorted |=> gateState == GATE_HIGH;
   endproperty
   a_short: assert property (p_short)
      else $error("gate not high on short");
endmodule // gate_drive_select

// [rtl/fault_timer.sv]
/*
 Latched fault timer for time spent with gate high or regulating while the shutdown output is high.
 Assumes run and clear come from flops of the same clock.
*/
`timescale 1ns/1ps
module fault_timer
   import tracker_pkg::*;
#(
   parameter logic [TIMER_W-1:0] LIMIT = FAULT_CYCLES_DEF
)(
   input  wire logic               clk_sys,
   input  wire logic               rst_n,
   input  wire logic               ce,
   input  wire logic               run,
   input  wire logic               clear,
   output logic [TIMER_W-1:0]      count,
   output logic                    faultQ
);
   logic expire;
   assign expire = run && (count == LIMIT - TIMER_W'(1));

   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         count <= '0;
      else if (ce) begin
         if (!run || expire)
            count <= '0;
         else
            count <= count + TIMER_W'(1);
      end
   end

   // Set wins over the unlatch condition
   always_ff @(posedge clk_sys) begin
      if (!rst_n)
         faultQ <= 1'b0;
      else if (ce) begin
         if (expire)
            faultQ <= 1'b1;
         else if (clear)
            faultQ <= 1'b0;
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);

   property p_count_clear;
      ce && !run |=> count == '0;
   endproperty
   a_count_clear: assert property (p_count_clear)
      else $error("timer not cleared");
   property p_fault_raise;
      ce && expire |=> faultQ;
   endproperty
   a_fault_raise: assert property (p_fault_raise)
      else $error("fault not raised at limit");
   property p_fault_hold;
      faultQ && !clear |=> faultQ;
   endproperty
   a_fault_hold: assert property (p_fault_hold)
      else $error("fault dropped without unlatch");
endmodule // fault_timer

// [testbench/supply_pair_model.sv]
/*
 Behavioural model of the external core and I/O supplies and their
 comparators. Assumes it is clocked by clk_sys and enabled by the
 shutdown output of the sequencer.
*/
`timescale 1ns/1ps
module supply_pair_model
   import tracker_pkg::*;
(
   input  wire logic       clk_sys,
   input  wire logic       rst_n,
   input  wire logic       supplyShutdownOut,
   input  wire logic       coreFails,
   input  wire logic       ioLags,
   input  wire logic [7:0] settleCycles,
   output logic            ioBelowCore,
   output logic            feedbackAbove
);
   logic [7:0] upCnt_q;

   // Time since the supplies were enabled, saturating
   always_ff @(posedge clk_sys) begin
      if (!rst_n || !supplyShutdownOut) begin
         upCnt_q <= 8'h00;
      end else if (upCnt_q != 8'hff) begin
         upCnt_q <= upCnt_q + 8'h01;
      end
   end

   // A lagging I/O supply stays under core for twice the settle time
   assign ioBelowCore = ioLags && ({1'b0, upCnt_q} < {settleCycles, 1'b0});
   // Core reaches its set point only when enabled and working
   assign feedbackAbove = supplyShutdownOut && !coreFails &&
                          (upCnt_q >= settleCycles);
endmodule // supply_pair_model

// [testbench/tracking_sequencer_test.sv]
/*
 Self-checking bench for the tracking sequencer with a supply model.
 Assumes the Avalon slave timing and register map of the design.
*/
`timescale 1ns/1ps
module tracking_sequencer_test
   import tracker_pkg::*;
;
   localparam int FCI = 16;
   localparam logic [TIMER_W-1:0] FC = TIMER_W'(FCI);
   logic clk_sys, rst_n, vccAboveHold, vccAboveOn, lockoutAbove;
   logic outputShorted, feedbackAbove, ioBelowCore, coreFails, ioLags;
   logic read, write, waitrequest, supplyShutdownOut, shutdownHoldActive;
   logic bleederEnable, faultLatched, irq, ce;
   logic [ADDR_W-1:0] address;
   logic [31:0]       writedata, readdata, rd;
   gate_t             shuntGateDrive;
   int                numErrors, testsRun, n;

   tracking_sequencer #(.FAULT_CYCLES(FC)) dut_u (
      .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce),
      .vccAboveHold(vccAboveHold), .vccAboveOn(vccAboveOn),
      .lockoutAbove(lockoutAbove), .ioBelowCore(ioBelowCore),
      .outputShorted(outputShorted), .feedbackAbove(feedbackAbove),
      .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .supplyShutdownOut(supplyShutdownOut),
      .shutdownHoldActive(shutdownHoldActive),
      .shuntGateDrive(shuntGateDrive), .bleederEnable(bleederEnable),
      .faultLatched(faultLatched), .irq(irq));

   supply_pair_model model_u (
      .clk_sys(clk_sys), .rst_n(rst_n),
      .supplyShutdownOut(supplyShutdownOut), .coreFails(coreFails),
      .ioLags(ioLags), .settleCycles(8'h04),
      .ioBelowCore(ioBelowCore), .feedbackAbove(feedbackAbove));

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   task automatic finish_test();
      if (numErrors == 0 && testsRun > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   task automatic fail(input string msg);
      numErrors++;
      $display("Error at %0t: %s", $time, msg);
   endtask

   task automatic checkBit(input logic got, input logic exp);
      testsRun++;
      if (got !== exp) fail("flag mismatch");
   endtask

   task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
      testsRun++;
      if (got !== exp) fail("register value mismatch");
   endtask

   task automatic checkGate(input gate_t got, input gate_t exp);
      testsRun++;
      if (got !== exp) fail("gate state mismatch");
   endtask

   task automatic wt(input int k);
      repeat (k) @(posedge clk_sys);
      #1;
   endtask

   // Holds the request until a rising edge that sees waitrequest low
   task automatic waitAck(output logic [31:0] data);
      logic busy;
      busy = 1'b1;
      data = '0;
      for (int i = 0; i < 20 && busy; i++) begin
         @(posedge clk_sys);
         busy = (waitrequest !== 1'b0);
         if (!busy) data = readdata;
      end
      if (busy) begin
         fail("bus wait timed out");
         finish_test();
      end
   endtask

   task automatic busWrite(input logic [ADDR_W-1:0] a,
                           input logic [31:0] d);
      logic [31:0] unused;
      @(posedge clk_sys);
      address   <= a;
      writedata <= d;
      write     <= 1'b1;
      waitAck(unused);
      write <= 1'b0;
   endtask

   task automatic busRead(input logic [ADDR_W-1:0] a,
                          output logic [31:0] d);
      @(posedge clk_sys);
      address <= a;
      read    <= 1'b1;
      waitAck(d);
      read <= 1'b0;
   endtask

   task automatic waitFault(output int k);
      for (k = 0; k < FCI + 8 && faultLatched !== 1'b1; k++) wt(1);
   endtask

   initial begin
      numErrors = 0; testsRun = 0;
      rst_n = 1'b0; vccAboveHold = 1'b0; vccAboveOn = 1'b0;
      lockoutAbove = 1'b0; outputShorted = 1'b0; coreFails = 1'b0;
      ioLags = 1'b0; address = '0; read = 1'b0; write = 1'b0;
      writedata = '0; ce = 1'b1;
      repeat (4) @(posedge clk_sys);
      rst_n <= 1'b1;
      wt(2);
      checkBit(shutdownHoldActive, 1'b0);
      @(posedge clk_sys);
      vccAboveHold <= 1'b1;
      ioLags       <= 1'b1;
      lockoutAbove <= 1'b1;
      wt(3);
      checkBit(shutdownHoldActive, 1'b1);
      checkBit(supplyShutdownOut, 1'b0);
      checkGate(shuntGateDrive, GATE_LOW);
      checkBit(bleederEnable, 1'b0);
      @(posedge clk_sys);
      lockoutAbove <= 1'b0;
      vccAboveOn   <= 1'b1;
      wt(3);
      checkBit(supplyShutdownOut, 1'b0);
      checkGate(shuntGateDrive, GATE_HIGH);
      checkBit(bleederEnable, 1'b1);
      busRead(OFS_STATUS, rd);
      checkWord(rd, 32'h00000158);
      busRead(OFS_IRQ_MASK, rd);
      checkWord(rd, {28'h0000000, MASK_RST});
      busWrite(5'h14, 32'hffffffff);
      busRead(5'h14, rd);
      checkWord(rd, 32'h00000000);
      busWrite(OFS_IRQ_STAT, 32'h0000000f);
      busWrite(OFS_IRQ_MASK, 32'h0000000f);
      wt(1);
      checkBit(irq, 1'b0);
      // Normal start: regulate, then standby once core settles
      @(posedge clk_sys);
      ioLags <= 1'b0;
      wt(30);
      checkGate(shuntGateDrive, GATE_REG);
      checkBit(faultLatched, 1'b0);
      @(posedge clk_sys);
      lockoutAbove <= 1'b1;
      wt(2);
      checkBit(supplyShutdownOut, 1'b1);
      checkBit(bleederEnable, 1'b0);
      checkBit(irq, 1'b1);
      busRead(OFS_IRQ_STAT, rd);
      checkWord(rd, 32'h00000002);
      busWrite(OFS_IRQ_STAT, 32'h00000002);
      wt(30);
      checkGate(shuntGateDrive, GATE_LOW);
      checkBit(faultLatched, 1'b0);
      checkBit(irq, 1'b0);
      // Core supply fails: regulation lasts past the fault time
      @(posedge clk_sys);
      coreFails <= 1'b1;
      waitFault(n);
      checkBit(faultLatched, 1'b1);
      checkBit(n >= FCI - 1 && n <= FCI + 4, 1'b1);
      wt(1);
      checkBit(supplyShutdownOut, 1'b0);
      checkGate(shuntGateDrive, GATE_REG);
      checkBit(irq, 1'b1);
      @(posedge clk_sys);
      coreFails <= 1'b0;
      wt(20);
      checkBit(faultLatched, 1'b1);
      checkBit(supplyShutdownOut, 1'b0);
      busRead(OFS_TIMER, rd);
      checkWord(rd, 32'h00000000);
      @(posedge clk_sys);
      lockoutAbove <= 1'b0;
      @(posedge clk_sys);
      lockoutAbove <= 1'b1;
      wt(3);
      checkBit(faultLatched, 1'b0);
      checkBit(supplyShutdownOut, 1'b1);
      busRead(OFS_IRQ_STAT, rd);
      checkWord(rd, 32'h00000007);
      busWrite(OFS_IRQ_STAT, 32'h00000007);
      busWrite(OFS_IRQ_MASK, 32'h00000000);
      // Output short: gate high at once, fault after the limit
      wt(20);
      @(posedge clk_sys);
      outputShorted <= 1'b1;
      wt(2);
      checkGate(shuntGateDrive, GATE_HIGH);
      waitFault(n);
      checkBit(faultLatched, 1'b1);
      wt(1);
      checkBit(supplyShutdownOut, 1'b0);
      checkGate(shuntGateDrive, GATE_HIGH);
      checkBit(irq, 1'b0);
      busRead(OFS_IRQ_STAT, rd);
      checkWord(rd, 32'h0000000d);
      busWrite(OFS_IRQ_MASK, 32'h0000000f);
      wt(1);
      checkBit(irq, 1'b1);
      busWrite(OFS_IRQ_STAT, 32'h0000000f);
      wt(1);
      checkBit(irq, 1'b0);
      // Supply cycling clears the latched fault
      @(posedge clk_sys);
      outputShorted <= 1'b0;
      vccAboveOn    <= 1'b0;
      wt(2);
      checkBit(faultLatched, 1'b0);
      checkGate(shuntGateDrive, GATE_LOW);
      checkBit(bleederEnable, 1'b0);
      @(posedge clk_sys);
      vccAboveOn <= 1'b1;
      wt(3);
      checkBit(supplyShutdownOut, 1'b1);
      busWrite(OFS_CTRL, 32'h00000001);
      wt(2);
      checkBit(supplyShutdownOut, 1'b0);
      checkBit(bleederEnable, 1'b1);
      busWrite(OFS_CTRL, 32'h00000000);
      wt(2);
      checkBit(supplyShutdownOut, 1'b1);
      // Clock enable low freezes the shutdown output
      @(posedge clk_sys);
      ce           <= 1'b0;
      lockoutAbove <= 1'b0;
      wt(3);
      checkBit(supplyShutdownOut, 1'b1);
      @(posedge clk_sys);
      ce <= 1'b1;
      wt(2);
      checkBit(supplyShutdownOut, 1'b0);
      finish_test();
   end
endmodule // tracking_sequencer_test
